// [shared/ccmi_pkg.sv]
// ccmi_pkg: command codes, field widths, reset values and carrier types for the
// calibration command interpreter. assumes nothing beyond a SystemVerilog compiler.
package ccmi_pkg;

  // command bytes
  localparam logic [7:0] CCMI_CMD_SECOND_ORDER = 8'h60;
  localparam logic [7:0] CCMI_CMD_SETTLING     = 8'h70;
  localparam logic [7:0] CCMI_CMD_GAIN_HI      = 8'h80;
  localparam logic [7:0] CCMI_CMD_GAIN_LO      = 8'h90;
  localparam logic [7:0] CCMI_CMD_OFFSET_HI    = 8'hA0;
  localparam logic [7:0] CCMI_CMD_OFFSET_LO    = 8'hB0;
  localparam logic [7:0] CCMI_CMD_UNLOCK       = 8'hE8;
  localparam logic [7:0] CCMI_CMD_CLIP_UPPER   = 8'h08;
  localparam logic [7:0] CCMI_CMD_CLIP_LOWER   = 8'h18;
  localparam logic [7:0] CCMI_CMD_CUSTOMER_ID0 = 8'h28;
  localparam logic [7:0] CCMI_CMD_CUSTOMER_ID1 = 8'h38;
  localparam logic [7:0] CCMI_CMD_CUSTOMER_ID2 = 8'h48;
  localparam logic [7:0] CCMI_CMD_MODE         = 8'h40;
  localparam logic [7:0] CCMI_CMD_ENTER_CMD    = 8'h50;

  // data bytes qualifying the mode commands
  localparam logic [7:0] CCMI_DATA_NORMAL      = 8'h00;
  localparam logic [7:0] CCMI_DATA_RAW         = 8'h10;
  localparam logic [7:0] CCMI_DATA_ENTER_CMD   = 8'h90;

  // field widths
  localparam int CCMI_GAIN_W   = 15;
  localparam int CCMI_OFFSET_W = 14;
  localparam int CCMI_BRIDGE_W = 14;
  localparam int CCMI_TEMP_W   = 11;

  // unity gains that make raw mode pass converter values unprocessed
  localparam logic [14:0] CCMI_GAIN_UNITY   = 15'h0800;
  localparam logic [7:0]  CCMI_TGAIN_UNITY  = 8'h80;

  // reset values of the stored settings
  localparam logic [7:0]  CCMI_RST_BYTE     = 8'h00;
  localparam logic [14:0] CCMI_RST_GAIN     = 15'h0800;
  localparam logic [13:0] CCMI_RST_OFFSET   = 14'h0000;

  // output frame length in bytes
  localparam logic [1:0]  CCMI_FRAME_BYTES  = 2'h3;
  localparam int          CCMI_FIFO_DEPTH   = 8;

  typedef enum logic [1:0] {
    CCMI_MODE_NORMAL,
    CCMI_MODE_COMMAND,
    CCMI_MODE_RAW
  } ccmi_mode_t;

  // one command/data pair as received from the serial link
  typedef struct packed {
    logic [7:0] command;
    logic [7:0] data;
  } ccmi_pair_t;

  // all stored calibration settings
  typedef struct packed {
    logic [7:0]  second_order_coeff;
    logic [6:0]  settling_time;
    logic [14:0] bridge_gain;
    logic [13:0] bridge_offset;
    logic [6:0]  clip_upper;
    logic [6:0]  clip_lower;
    logic [7:0]  customer_id_byte0;
    logic [7:0]  customer_id_byte1;
    logic [7:0]  customer_id_byte2;
  } ccmi_coeffs_t;

  // one measurement: uncorrected converter values plus the corrected results
  typedef struct packed {
    logic [13:0] raw_bridge;
    logic [10:0] raw_temp;
    logic [13:0] corr_bridge;
    logic [10:0] corr_temp;
  } ccmi_meas_t;

endpackage

// [design/ccmi_fifo.sv]
// ccmi_fifo: small synchronous fifo with valid/ready on both sides.
// assumes a single clock and a synchronous active high reset.
`timescale 1ns/10ps
module ccmi_fifo
  import ccmi_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = CCMI_FIFO_DEPTH
) (
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } ccmi_fifo_state_t;

  ccmi_fifo_state_t state;
  ccmi_fifo_state_t next_state;
  logic             push;
  logic             pop;

  assign in_ready_o  = (state.count != (AW+1)'(DEPTH));
  assign out_valid_o = (state.count != '0);
  assign out_data_o  = state.mem[state.rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    next_state = state;
    if (push) begin
      next_state.mem[state.wr_ptr] = in_data_i;
      next_state.wr_ptr = (state.wr_ptr == AW'(DEPTH - 1)) ? '0 : state.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_state.rd_ptr = (state.rd_ptr == AW'(DEPTH - 1)) ? '0 : state.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_state.count = state.count + 1'b1;
    end else if (pop && !push) begin
      next_state.count = state.count - 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule

// [design/ccmi_interpreter.sv]
// ccmi_interpreter: takes command/data pairs from the one-wire receiver, keeps
// the calibration settings and the write lock, and streams raw or corrected frames.
// assumes pairs arrive already assembled, one pulse per pair, on clock_i.
//
// Contract
// - command 60 stores second order coefficient
// - 80/90 load 15-bit gain high/low
// - A0/B0 load 14-bit offset high/low
// - E8 lifts storage lock until reset
// - 08 loads upper clip limit, MSB zero
// - 18 loads lower clip limit, MSB zero
// - 28/38/48 store three customer ID bytes
// - raw mode at unity gains outputs converter values
// - frame is bridge high, bridge low, temperature
// - bridge high byte top two bits zero
// - temperature byte is low of 11 bits
// - 4000 leaves command mode to normal
// - 5090 enters command mode
`timescale 1ns/10ps
module ccmi_interpreter
  import ccmi_pkg::*;
#(
  parameter int FIFO_DEPTH = CCMI_FIFO_DEPTH
) (
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  input  wire ccmi_pair_t   pair_i,
  input  wire logic         pair_valid_i,
  input  wire ccmi_meas_t   meas_i,
  input  wire logic         meas_valid_i,
  input  wire logic [7:0]   temp_gain_i,
  output logic [7:0]        out_byte_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic              meas_ready_o,
  output ccmi_coeffs_t      coeffs_o,
  output ccmi_mode_t        mode_o,
  output logic              lock_suspended_o,
  output logic              raw_active_o
);

  typedef struct packed {
    ccmi_mode_t   mode;
    ccmi_coeffs_t coeffs;
    logic         lock_suspended;
    logic [1:0]   byte_idx;
    logic         sending;
    logic [23:0]  frame;
    logic [7:0]   out_byte;
    logic         out_valid;
    logic         meas_ready;
    logic         raw_active;
  } ccmi_state_t;

  ccmi_state_t state;
  ccmi_state_t next_state;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        fifo_pop;

  // recognises a command byte accepted in command mode
  function automatic logic ccmi_known_cmd(input logic [7:0] c);
    unique case (c)
      CCMI_CMD_SECOND_ORDER, CCMI_CMD_SETTLING, CCMI_CMD_GAIN_HI, CCMI_CMD_GAIN_LO,
      CCMI_CMD_OFFSET_HI, CCMI_CMD_OFFSET_LO, CCMI_CMD_UNLOCK, CCMI_CMD_CLIP_UPPER,
      CCMI_CMD_CLIP_LOWER, CCMI_CMD_CUSTOMER_ID0, CCMI_CMD_CUSTOMER_ID1, CCMI_CMD_CUSTOMER_ID2,
      CCMI_CMD_MODE, CCMI_CMD_ENTER_CMD:
        ccmi_known_cmd = 1'b1;
      default:
        ccmi_known_cmd = 1'b0;
    endcase
  endfunction

  // builds the three-byte frame for one measurement
  function automatic logic [23:0] ccmi_frame(input logic [13:0] bridge,
                                             input logic [10:0] temp);
    // top two bits of the bridge high byte padded with zero; top three temp bits dropped
    ccmi_frame = {2'b00, bridge[13:8], bridge[7:0], temp[7:0]};
  endfunction

  logic raw_unity;
  assign raw_unity = (state.coeffs.bridge_gain == CCMI_GAIN_UNITY)
                  && (temp_gain_i == CCMI_TGAIN_UNITY);

  always_comb begin
    next_state = state;
    next_state.out_valid  = 1'b0;
    next_state.meas_ready = 1'b0;

    if (pair_valid_i) begin
      if (pair_i.command == CCMI_CMD_ENTER_CMD && pair_i.data == CCMI_DATA_ENTER_CMD) begin
        next_state.mode = CCMI_MODE_COMMAND;
      end else if (state.mode == CCMI_MODE_COMMAND && ccmi_known_cmd(pair_i.command)) begin
        unique case (pair_i.command)
          CCMI_CMD_SECOND_ORDER: next_state.coeffs.second_order_coeff = pair_i.data;
          CCMI_CMD_SETTLING:     next_state.coeffs.settling_time = pair_i.data[6:0];
          CCMI_CMD_GAIN_HI:      next_state.coeffs.bridge_gain[14:8] = pair_i.data[6:0];
          CCMI_CMD_GAIN_LO:      next_state.coeffs.bridge_gain[7:0] = pair_i.data;
          CCMI_CMD_OFFSET_HI:    next_state.coeffs.bridge_offset[13:8] = pair_i.data[5:0];
          CCMI_CMD_OFFSET_LO:    next_state.coeffs.bridge_offset[7:0] = pair_i.data;
          CCMI_CMD_UNLOCK:       next_state.lock_suspended = 1'b1;
          CCMI_CMD_CLIP_UPPER:   next_state.coeffs.clip_upper = pair_i.data[6:0];
          CCMI_CMD_CLIP_LOWER:   next_state.coeffs.clip_lower = pair_i.data[6:0];
          CCMI_CMD_CUSTOMER_ID0: next_state.coeffs.customer_id_byte0 = pair_i.data;
          CCMI_CMD_CUSTOMER_ID1: next_state.coeffs.customer_id_byte1 = pair_i.data;
          CCMI_CMD_CUSTOMER_ID2: next_state.coeffs.customer_id_byte2 = pair_i.data;
          CCMI_CMD_MODE: begin
            if (pair_i.data == CCMI_DATA_NORMAL) begin
              next_state.mode = CCMI_MODE_NORMAL;
            // raw only reachable from command mode
            end else if (pair_i.data == CCMI_DATA_RAW) begin
              next_state.mode = CCMI_MODE_RAW;
            end
          end
          // a repeated 50 with other data is harmless
          CCMI_CMD_ENTER_CMD: next_state.mode = state.mode;
        endcase
      end
      // anything else leaves all settings alone
    end

    // converter values only with unity gains in raw mode
    next_state.raw_active = (next_state.mode == CCMI_MODE_RAW) && raw_unity;

    // frame builder: one measurement in flight, three pushes into the fifo
    if (!state.sending) begin
      next_state.meas_ready = 1'b1;
      if (meas_valid_i && state.meas_ready) begin
        next_state.meas_ready = 1'b0;
        next_state.sending    = 1'b1;
        next_state.byte_idx   = '0;
        next_state.frame = state.raw_active
                         ? ccmi_frame(meas_i.raw_bridge, meas_i.raw_temp)
                         : ccmi_frame(meas_i.corr_bridge, meas_i.corr_temp);
      end
    end else if (fifo_in_ready) begin
      next_state.frame = {state.frame[15:0], 8'h00};
      if (state.byte_idx == CCMI_FRAME_BYTES - 2'h1) begin
        next_state.sending = 1'b0;
      end else begin
        next_state.byte_idx = state.byte_idx + 2'h1;
      end
    end

    // output register stage fed from the fifo
    if (state.out_valid && !out_ready_i) begin
      next_state.out_valid = 1'b1;
    end else if (fifo_out_valid) begin
      next_state.out_valid = 1'b1;
      next_state.out_byte  = fifo_out_data;
    end
  end

  assign fifo_pop = fifo_out_valid && !(state.out_valid && !out_ready_i);

  ccmi_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .reset_i     (reset_i),
    .in_data_i   (state.frame[23:16]),
    .in_valid_i  (state.sending),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop)
  );

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state                           <= '0;
      state.mode                      <= CCMI_MODE_NORMAL;
      state.coeffs.second_order_coeff <= CCMI_RST_BYTE;
      state.coeffs.bridge_gain        <= CCMI_RST_GAIN;
      state.coeffs.bridge_offset      <= CCMI_RST_OFFSET;
      state.lock_suspended            <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign out_byte_o       = state.out_byte;
  assign out_valid_o      = state.out_valid;
  assign meas_ready_o     = state.meas_ready;
  assign coeffs_o         = state.coeffs;
  assign mode_o           = state.mode;
  assign lock_suspended_o = state.lock_suspended;
  assign raw_active_o     = state.raw_active;
endmodule

// [testbench/ccmi_interpreter_chk.sv]
// ccmi_interpreter_chk: port-level assertions for the command interpreter.
// assumes it is bound onto ccmi_interpreter; one clock, synchronous reset.
`timescale 1ns/10ps
module ccmi_interpreter_chk
  import ccmi_pkg::*;
#(
  parameter int FIFO_DEPTH = CCMI_FIFO_DEPTH
) (
  input wire logic         clock_i,
  input wire logic         reset_i,
  input wire ccmi_pair_t   pair_i,
  input wire logic         pair_valid_i,
  input wire logic [7:0]   temp_gain_i,
  input wire ccmi_coeffs_t coeffs_o,
  input wire ccmi_mode_t   mode_o,
  input wire logic         lock_suspended_o,
  input wire logic         raw_active_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic cm;
  assign cm = pair_valid_i && mode_o == CCMI_MODE_COMMAND;
  property p_enter;
    pair_valid_i && pair_i == 16'h5090 && mode_o == CCMI_MODE_NORMAL |=> mode_o == CCMI_MODE_COMMAND;
  endproperty
  a_enter: assert property (p_enter) else $error("no command mode");
  property p_second_order;
    cm && pair_i.command == 8'h60 |=> coeffs_o.second_order_coeff == $past(pair_i.data);
  endproperty
  a_second_order: assert property (p_second_order) else $error("second order not stored");
  property p_gain;
    cm && pair_i.command == 8'h80 |=> coeffs_o.bridge_gain[14:8] == $past(pair_i.data[6:0]);
  endproperty
  a_gain: assert property (p_gain) else $error("gain high not stored");
  property p_off;
    cm && pair_i.command == 8'hB0 |=> coeffs_o.bridge_offset[7:0] == $past(pair_i.data);
  endproperty
  a_off: assert property (p_off) else $error("offset low not stored");
  // once lifted the lock stays lifted until reset
  property p_lock;
    lock_suspended_o || (cm && pair_i.command == 8'hE8) |=> lock_suspended_o;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not suspended");
  property p_nom;
    cm && pair_i == 16'h4000 |=> mode_o == CCMI_MODE_NORMAL;
  endproperty
  a_nom: assert property (p_nom) else $error("normal mode not resumed");
  property p_ign;
    pair_valid_i && mode_o != CCMI_MODE_COMMAND |=> $stable(coeffs_o);
  endproperty
  a_ign: assert property (p_ign) else $error("settings changed outside command mode");
  property p_unity;
    // a pair in the same cycle may legally leave raw mode
    !pair_valid_i && mode_o == CCMI_MODE_RAW && coeffs_o.bridge_gain == 15'h0800
      && temp_gain_i == 8'h80
      |=> raw_active_o;
  endproperty
  a_unity: assert property (p_unity) else $error("raw output not active");
endmodule

bind ccmi_interpreter ccmi_interpreter_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .clock_i(clock_i), .reset_i(reset_i), .pair_i(pair_i), .pair_valid_i(pair_valid_i),
  .temp_gain_i(temp_gain_i), .coeffs_o(coeffs_o), .mode_o(mode_o),
  .lock_suspended_o(lock_suspended_o), .raw_active_o(raw_active_o));

// [testbench/ccmi_master.sv]
// ccmi_master: calibration master model; sends pairs and collects output bytes.
// assumes the bench calls send() and reads got on the interpreter's clock.
`timescale 1ns/10ps
module ccmi_master
  import ccmi_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       valid_i,
  input  wire logic       ready_i,
  output ccmi_pair_t      pair_o,
  output logic            pair_valid_o
);
  logic [7:0] got[$];
  initial begin
    pair_o = '0;
    pair_valid_o = 1'b0;
  end
  // idle pair lines show the inverse so a stale pair never looks valid
  task automatic send(input logic [7:0] c, input logic [7:0] d);
    @(negedge clock_i);
    pair_o = {c, d};
    pair_valid_o = 1'b1;
    @(negedge clock_i);
    pair_valid_o = 1'b0;
    pair_o = ~pair_o;
  endtask
  always @(posedge clock_i) if (valid_i && ready_i) got.push_back(byte_i);
endmodule

// [testbench/tb_ccmi_interpreter.sv]
// tb_ccmi_interpreter: self-checking bench for the command interpreter.
// assumes ccmi_master as pair source and byte sink; 10 MHz clock.
`timescale 1ns/10ps
module tb_ccmi_interpreter;
  import ccmi_pkg::*;
  logic clock_i, reset_i, pair_valid_i, meas_valid_i, out_valid_o, out_ready_i;
  logic meas_ready_o, lock_suspended_o, raw_active_o, elock, rnd, rdy;
  logic [7:0] temp_gain_i, out_byte_o, exp_q[$];
  ccmi_pair_t pair_i;
  ccmi_meas_t meas_i;
  ccmi_coeffs_t coeffs_o, em;
  ccmi_mode_t mode_o, emode;
  int seed = 32'h318d_4b97;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;
  logic [7:0] cmds[13] = '{8'h60, 8'h70, 8'h80, 8'h90, 8'hA0, 8'hB0, 8'h08, 8'h18, 8'h28,
                           8'h38, 8'h48, 8'hC0, 8'hE8};
  ccmi_interpreter dut (.clock_i(clock_i), .reset_i(reset_i), .pair_i(pair_i),
    .pair_valid_i(pair_valid_i), .meas_i(meas_i), .meas_valid_i(meas_valid_i),
    .temp_gain_i(temp_gain_i), .out_byte_o(out_byte_o), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i), .meas_ready_o(meas_ready_o), .coeffs_o(coeffs_o),
    .mode_o(mode_o), .lock_suspended_o(lock_suspended_o), .raw_active_o(raw_active_o));
  ccmi_master master (.clock_i(clock_i), .byte_i(out_byte_o), .valid_i(out_valid_o),
    .ready_i(out_ready_i), .pair_o(pair_i), .pair_valid_o(pair_valid_i));
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // single driver of the sink ready: random back-pressure or the level held in rdy
  always @(negedge clock_i) out_ready_i <= rnd ? 1'($random(seed)) : rdy;
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    chk(128'(g), 128'(e));
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic do_reset();
    @(negedge clock_i);
    reset_i = 1'b1;
    repeat (20) @(negedge clock_i);
    reset_i = 1'b0;
    em = '0;
    em.bridge_gain = CCMI_RST_GAIN;
    emode = CCMI_MODE_NORMAL;
    elock = 1'b0;
  endtask
  function automatic logic [7:0] mask(input logic [7:0] c);
    return c == 8'hA0 ? 8'h3f : (c inside {8'h70, 8'h80, 8'h08, 8'h18}) ? 8'h7f : 8'hff;
  endfunction
  task automatic pr(input logic [7:0] c, input logic [7:0] d);
    master.send(c, d);
    if (emode != CCMI_MODE_COMMAND) begin
      if ({c, d} == 16'h5090) emode = CCMI_MODE_COMMAND;
    end else begin
      case (c)
        8'h60: em.second_order_coeff = d;
        8'h70: em.settling_time = d[6:0];
        8'h80: em.bridge_gain[14:8] = d[6:0];
        8'h90: em.bridge_gain[7:0] = d;
        8'hA0: em.bridge_offset[13:8] = d[5:0];
        8'hB0: em.bridge_offset[7:0] = d;
        8'h08: em.clip_upper = d[6:0];
        8'h18: em.clip_lower = d[6:0];
        8'h28: em.customer_id_byte0 = d;
        8'h38: em.customer_id_byte1 = d;
        8'h48: em.customer_id_byte2 = d;
        8'hE8: elock = 1'b1;
        8'h40: emode = d == 8'h00 ? CCMI_MODE_NORMAL : d == 8'h10 ? CCMI_MODE_RAW : emode;
        default: ;
      endcase
    end
    chk(128'(coeffs_o), 128'(em));
    chk(128'(mode_o), 128'(emode));
    chk(128'(lock_suspended_o), 128'(elock));
  endtask
  task automatic frame();
    ccmi_meas_t m;
    logic raw;
    int k;
    m = 50'({$random(seed), $random(seed)});
    @(negedge clock_i);
    meas_i = m;
    meas_valid_i = 1'b1;
    k = 0;
    while (meas_ready_o !== 1'b1 && k < 300) begin
      @(negedge clock_i);
      k++;
    end
    if (k == 300) miscompares++;
    raw = emode == CCMI_MODE_RAW && em.bridge_gain == 15'h0800 && temp_gain_i == 8'h80;
    exp_q.push_back({2'b00, raw ? m.raw_bridge[13:8] : m.corr_bridge[13:8]});
    exp_q.push_back(raw ? m.raw_bridge[7:0] : m.corr_bridge[7:0]);
    exp_q.push_back(raw ? m.raw_temp[7:0] : m.corr_temp[7:0]);
    @(negedge clock_i);
    meas_valid_i = 1'b0;
    meas_i = ~m;
  endtask
  initial begin
    reset_i = 1'b1;
    meas_i = '0;
    meas_valid_i = 1'b0;
    temp_gain_i = 8'h80;
    rdy = 1'b1;
    rnd = 1'b0;
    do_reset();
    chk(128'(coeffs_o), 128'(em));
    pr(8'h60, 8'h55);
    pr(8'h50, 8'h90);
    repeat (3) foreach (cmds[i]) pr(cmds[i], 8'($random(seed)) & mask(cmds[i]));
    pr(8'h40, 8'h00);
    pr(8'h50, 8'h90);
    pr(8'h80, 8'h08);
    pr(8'h90, 8'h00);
    pr(8'h40, 8'h10);
    repeat (2) @(negedge clock_i);
    chk(128'(raw_active_o), 128'(1'b1));
    rdy = 1'b0;
    repeat (2) frame();
    repeat (20) @(negedge clock_i);
    rnd = 1'b1;
    repeat (4) frame();
    temp_gain_i = 8'h7f;
    repeat (2) @(negedge clock_i);
    chk(128'(raw_active_o), 128'(1'b0));
    frame();
    n = 0;
    while (master.got.size() < exp_q.size() && n < 2000) begin
      @(negedge clock_i);
      n++;
    end
    chk(128'(master.got.size()), 128'(exp_q.size()));
    foreach (exp_q[i]) chk_byte(master.got[i], exp_q[i]);
    do_reset();
    pr(8'h50, 8'h90);
    tally_and_finish();
  end
endmodule
